// ---- design/lmpu_check.sv ----
`timescale 1ns/1ps
`default_nettype none

// Behaviour
// - Guest accesses get two-layer checking when virtualised.
// - Entries are host-owned or guest-configurable.
// - Guest access needs both layers; else violation.
// - Guest layer evaluates only guest entries.
// - Guest host-layer enable is guest enable bit.
// - Guest enable set checks supervisor accesses too.
// - Host access uses host entries only.
// - Host access enable follows general enable bit.
// - Host supervisor checking follows supervisor-protect bit.
// - Identifier registers frozen in Guest mode.
// - Two banks, chosen by bank-select register.
// - Read-only field reports bank count.
// - Unselected bank affects nothing.
// - Selected bank serves checks and entry access.
// - Bank switch is immediate, no copying.
// - Bank switch leaves identifiers unchanged.
// - Bulk store/load moves whole selected bank.
// - Bulk ops leave other banks untouched.
// - Guest bulk store also writes host entries.
// - Guest bulk load reads, discards host slots.
// - Host-slot bulk accesses still raise exceptions.
// - Final XWR bit is AND of layers.
module lmpu_check
  import lmpu_pkg::*;
#(
  parameter int NUM_ENTRIES = 8,
  parameter int NUM_BANKS   = 2,
  parameter int NUM_IDS     = 8
) (
  // Clock and reset
  input  wire  logic               ref_clk,
  input  wire  logic               rst_n,
  // Virtualisation state from core
  input  wire  logic               virt_mode,
  input  wire  logic               core_guest,
  // Access check port
  input  wire  lmpu_pkg::lmpu_acc_t acc,
  output logic                     acc_valid,
  output lmpu_pkg::lmpu_res_t      acc_res,
  // Bulk transfer data port
  input  wire  logic               bulk_store_start,
  input  wire  logic               bulk_load_start,
  output logic                     bulk_req,
  output logic                     bulk_we,
  output logic [31:0]              bulk_addr,
  output logic [31:0]              bulk_wdata,
  input  wire  logic               bulk_ack,
  input  wire  logic               bulk_err,
  input  wire  logic [31:0]        bulk_rdata,
  input  wire  logic [31:0]        bulk_base,
  output logic                     bulk_busy,
  output logic                     bulk_fault,
  // Wishbone slave
  input  wire  logic               wb_cyc_i,
  input  wire  logic               wb_stb_i,
  input  wire  logic               wb_we_i,
  input  wire  logic [7:0]         wb_adr_i,
  input  wire  logic [3:0]         wb_sel_i,
  input  wire  logic [31:0]        wb_dat_i,
  output logic [31:0]              wb_dat_o,
  output logic                     wb_ack_o,
  output logic                     wb_err_o
);
  import lmpu_pkg::*;

  localparam int IW = $clog2(NUM_ENTRIES);
  localparam int BW = (NUM_BANKS > 1) ? $clog2(NUM_BANKS) : 1;
  localparam int DW = $clog2(NUM_IDS);
  localparam int CW = $clog2(NUM_ENTRIES * WORDS_PER_ENTRY + 1);
  localparam int TOTAL = NUM_ENTRIES * WORDS_PER_ENTRY;

  lmpu_entry_t       ent [NUM_BANKS][NUM_ENTRIES];
  logic [31:0]       mode;
  logic [BW-1:0]     bank;
  logic [IW-1:0]     index;
  logic [31:0]       ident [NUM_IDS];

  wire guest_now = virt_mode & core_guest;
  wire pe   = mode[MODE_PE_BIT];
  wire svp  = mode[MODE_SVP_BIT];
  wire gpe  = mode[MODE_GPE_BIT];

  // Access check: per-entry hit and XWR per layer
  logic [NUM_ENTRIES-1:0] id_ok, hit, is_guest;
  logic [2:0]             perm [NUM_ENTRIES];
  logic [2:0]             host_xwr, guest_xwr;

  always_comb begin
    host_xwr  = 3'h0;
    guest_xwr = 3'h0;
    for (int i = 0; i < NUM_ENTRIES; i++) begin
      id_ok[i] = 1'b0;
      for (int d = 0; d < NUM_IDS; d++) begin
        if (ident[d][7:0] == ent[bank][i].attr[ATTR_ID_LSB +: 8]) begin
          id_ok[i] = 1'b1;
        end
      end
      hit[i] = ent[bank][i].attr[ATTR_EN_BIT] & id_ok[i]
               & (acc.addr >= ent[bank][i].lower) & (acc.addr <= ent[bank][i].upper);
      is_guest[i] = ent[bank][i].attr[ATTR_GUEST_BIT];
      perm[i] = acc.sv ?
        {ent[bank][i].attr[ATTR_SX_BIT], ent[bank][i].attr[ATTR_SW_BIT],
         ent[bank][i].attr[ATTR_SR_BIT]} :
        {ent[bank][i].attr[ATTR_UX_BIT], ent[bank][i].attr[ATTR_UW_BIT],
         ent[bank][i].attr[ATTR_UR_BIT]};
      if (hit[i] && is_guest[i]) begin
        guest_xwr = guest_xwr | perm[i];
      end
      if (hit[i] && !is_guest[i]) begin
        host_xwr = host_xwr | perm[i];
      end
    end
  end

  // Layer enables
  wire host_on_guest = gpe;
  wire host_on_host  = pe & (~acc.sv | svp);
  wire host_layer_on = guest_now ? host_on_guest : host_on_host;
  wire guest_layer_on = guest_now & pe & (~acc.sv | svp);
  wire [2:0] host_res  = host_layer_on  ? host_xwr  : 3'h7;
  wire [2:0] guest_res = guest_layer_on ? guest_xwr : 3'h7;
  wire [2:0] final_xwr = host_res & guest_res;
  wire [2:0] need      = {acc.ex, acc.wr, acc.rd};
  wire       viol      = acc.valid & |(need & ~final_xwr);

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      acc_valid <= 1'b0;
      acc_res   <= '0;
    end else begin
      acc_valid         <= acc.valid;
      acc_res.violation <= viol;
      acc_res.xwr       <= final_xwr;
    end
  end

  // Bulk transfer sequencer
  typedef enum logic [1:0] {BK_IDLE, BK_STORE, BK_LOAD} lmpu_bk_t;
  lmpu_bk_t     bst;
  logic [CW-1:0] cnt;
  logic          bguest;
  wire [IW-1:0] b_ent  = IW'(cnt / CW'(WORDS_PER_ENTRY));
  wire [1:0]    b_word = 2'(cnt % CW'(WORDS_PER_ENTRY));
  wire          b_host_slot = ~ent[bank][b_ent].attr[ATTR_GUEST_BIT];
  wire          b_drop = bguest & b_host_slot;
  wire          b_last = (cnt == CW'(TOTAL - 1));
  wire [31:0]   b_word_val = (b_word == 2'd0) ? ent[bank][b_ent].attr :
                             (b_word == 2'd1) ? ent[bank][b_ent].upper :
                                                ent[bank][b_ent].lower;
  // Next word is staged on ack so write data stands with the request
  // Guest load judges the drop from the attribute word already held
  wire [CW-1:0] cnt_n   = cnt + CW'(1);
  wire [IW-1:0] n_ent   = IW'(cnt_n / CW'(WORDS_PER_ENTRY));
  wire [1:0]    n_word  = 2'(cnt_n % CW'(WORDS_PER_ENTRY));
  wire [31:0]   next_wdata = (n_word == 2'd0) ? ent[bank][n_ent].attr :
                             (n_word == 2'd1) ? ent[bank][n_ent].upper :
                                                ent[bank][n_ent].lower;

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      bst        <= BK_IDLE;
      cnt        <= '0;
      bguest     <= 1'b0;
      bulk_req   <= 1'b0;
      bulk_we    <= 1'b0;
      bulk_addr  <= 32'h0;
      bulk_wdata <= 32'h0;
      bulk_fault <= 1'b0;
    end else begin
      case (bst)
        BK_IDLE: begin
          cnt <= '0;
          if (bulk_store_start || bulk_load_start) begin
            bst        <= bulk_store_start ? BK_STORE : BK_LOAD;
            bguest     <= guest_now;
            bulk_req   <= 1'b1;
            bulk_we    <= bulk_store_start;
            bulk_addr  <= bulk_base;
            bulk_fault <= 1'b0;
            bulk_wdata <= ent[bank][0].attr;
          end
        end
        BK_STORE, BK_LOAD: begin
          if (bulk_err) begin
            bst        <= BK_IDLE;
            bulk_req   <= 1'b0;
            bulk_fault <= 1'b1;
          end else if (bulk_ack) begin
            if (b_last) begin
              bst      <= BK_IDLE;
              bulk_req <= 1'b0;
            end else begin
              cnt       <= cnt + CW'(1);
              bulk_addr <= bulk_addr + 32'h4;
            end
          end
          if (bst == BK_STORE && bulk_ack && !b_last) begin
            bulk_wdata <= next_wdata;
          end
        end
        default: bst <= BK_IDLE;
      endcase
    end
  end

  assign bulk_busy = (bst != BK_IDLE);
  wire   bulk_wr_en = (bst == BK_LOAD) & bulk_ack & ~bulk_err & ~b_drop;

  // Wishbone register access
  wire        wb_req   = wb_cyc_i & wb_stb_i & ~wb_ack_o & ~wb_err_o;
  wire        hit_mode = (wb_adr_i == OFF_MODE);
  wire        hit_bank = (wb_adr_i == OFF_BANK);
  wire        hit_cfg  = (wb_adr_i == OFF_CFG);
  wire        hit_idx  = (wb_adr_i == OFF_INDEX);
  wire        hit_attr = (wb_adr_i == OFF_ATTR);
  wire        hit_up   = (wb_adr_i == OFF_UPPER);
  wire        hit_lo   = (wb_adr_i == OFF_LOWER);
  wire        hit_id   = (wb_adr_i >= OFF_IDENT) & (wb_adr_i < OFF_IDENT + 8'(4 * NUM_IDS));
  wire        hit_st   = (wb_adr_i == OFF_STATUS + 8'(4 * (NUM_IDS - 1)));
  wire [DW-1:0] id_sel = DW'((wb_adr_i - OFF_IDENT) >> 2);
  wire        mapped   = hit_mode | hit_bank | hit_cfg | hit_idx | hit_attr | hit_up
                         | hit_lo | hit_id | hit_st;
  wire        wr       = wb_req & wb_we_i & mapped & ~bulk_busy;
  wire        host_ent = ~ent[bank][index].attr[ATTR_GUEST_BIT];
  wire        ent_lock = guest_now & host_ent;
  wire [31:0] wmask    = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}}, {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
  wire [31:0] cfg_val  = {16'h0, 8'(NUM_BANKS), 8'(NUM_ENTRIES)};
  wire [31:0] st_val   = {29'h0, bulk_fault, bulk_busy, guest_now};

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [31:0] m);
    merge = (old & ~m) | (nw & m);
  endfunction : merge

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      mode  <= MODE_RESET;
      bank  <= BW'(BANK_RESET);
      index <= '0;
      for (int b = 0; b < NUM_BANKS; b++) begin
        for (int i = 0; i < NUM_ENTRIES; i++) begin
          ent[b][i] <= {ENTRY_RESET, ENTRY_RESET, ENTRY_RESET};
        end
      end
      for (int d = 0; d < NUM_IDS; d++) begin
        ident[d] <= IDENT_RESET;
      end
    end else begin
      if (wr && hit_mode) begin
        mode <= merge(mode, wb_dat_i, wmask) & 32'h7;
      end
      if (wr && hit_bank && !guest_now) begin
        bank <= BW'(wb_dat_i) ;
      end
      if (wr && hit_idx) begin
        index <= IW'(wb_dat_i);
      end
      if (wr && hit_id && !guest_now) begin
        ident[id_sel] <= merge(ident[id_sel], wb_dat_i, wmask);
      end
      if (wr && hit_attr && !ent_lock) begin
        ent[bank][index].attr <= merge(ent[bank][index].attr, wb_dat_i, wmask);
      end
      if (wr && hit_up && !ent_lock) begin
        ent[bank][index].upper <= merge(ent[bank][index].upper, wb_dat_i, wmask);
      end
      if (wr && hit_lo && !ent_lock) begin
        ent[bank][index].lower <= merge(ent[bank][index].lower, wb_dat_i, wmask);
      end
      if (bulk_wr_en) begin
        case (b_word)
          2'd0:    ent[bank][b_ent].attr  <= bulk_rdata;
          2'd1:    ent[bank][b_ent].upper <= bulk_rdata;
          default: ent[bank][b_ent].lower <= bulk_rdata;
        endcase
      end
    end
  end

  wire [31:0] rd_val = hit_mode ? mode :
                       hit_bank ? 32'(bank) :
                       hit_cfg  ? cfg_val :
                       hit_idx  ? 32'(index) :
                       hit_attr ? ent[bank][index].attr :
                       hit_up   ? ent[bank][index].upper :
                       hit_lo   ? ent[bank][index].lower :
                       hit_id   ? ident[id_sel] :
                       hit_st   ? st_val : 32'h0;

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      wb_ack_o <= 1'b0;
      wb_err_o <= 1'b0;
      wb_dat_o <= 32'h0;
    end else begin
      wb_ack_o <= wb_req & mapped;
      wb_err_o <= wb_req & ~mapped;
      wb_dat_o <= (wb_req & ~wb_we_i) ? rd_val : 32'h0;
    end
  end

  // Checks
  both_layers_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (acc.valid && guest_now && gpe && pe && |(need & ~host_xwr))
      |=> acc_res.violation)
    else $error("guest access passed despite host layer denial");

  host_only_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (acc.valid && !guest_now && !pe) |=> !acc_res.violation)
    else $error("host access denied with protection off");

  bank_apply_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (wr && hit_bank && !guest_now) |=> (bank == $past(BW'(wb_dat_i))))
    else $error("bank select not applied next cycle");

  ident_freeze_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (wr && hit_id && guest_now) |=> (ident[$past(id_sel)] == $past(ident[id_sel])))
    else $error("identifier changed from guest mode");

  guest_host_ent_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (wr && hit_attr && ent_lock)
      |=> (ent[$past(bank)][$past(index)].attr == $past(ent[bank][index].attr)))
    else $error("guest wrote a host entry");

  final_and_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (acc.valid && host_layer_on && guest_layer_on) |=> acc_res.xwr == $past(host_xwr & guest_xwr))
    else $error("final result is not the layer product");

  bulk_len_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (bulk_busy && bulk_ack && !bulk_err && b_last) |=> !bulk_busy ##0 !bulk_req)
    else $error("bulk transfer did not end after last word");

  wb_answer_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    wb_req |=> (wb_ack_o ^ wb_err_o) ##1 !(wb_ack_o | wb_err_o))
    else $error("bus answer not one cycle");

  host_layer_deny_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (acc.valid && !guest_now && pe && !acc.sv && |(need & ~host_xwr)) |=> acc_res.violation)
    else $error("host access passed despite host entry denial");

  host_sv_free_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (acc.valid && !guest_now && acc.sv && !svp) |=> !acc_res.violation)
    else $error("host supervisor access checked with supervisor protect off");

  guest_sv_check_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (acc.valid && guest_now && gpe && acc.sv && |(need & ~host_xwr)) |=> acc_res.violation)
    else $error("guest supervisor access skipped the host layer");

  guest_layer_deny_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (acc.valid && guest_now && pe && !acc.sv && |(need & ~guest_xwr)) |=> acc_res.violation)
    else $error("guest access passed despite guest entry denial");

  store_word_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (bst == BK_STORE) |-> (bulk_wdata == b_word_val))
    else $error("bulk store word does not match the entry");

  load_drop_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (bst == BK_LOAD && bulk_ack && !bulk_err && b_drop)
      |=> (ent[$past(bank)][$past(b_ent)] == $past(ent[bank][b_ent])))
    else $error("guest bulk load changed a host entry");

  load_write_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (bst == BK_LOAD && bulk_ack && !bulk_err && !b_drop && b_word == 2'd1)
      |=> (ent[$past(bank)][$past(b_ent)].upper == $past(bulk_rdata)))
    else $error("bulk load did not store the upper bound word");

  bulk_err_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (bulk_busy && bulk_err) |=> (bulk_fault && !bulk_busy))
    else $error("bus error did not end the bulk transfer with a fault");

endmodule : lmpu_check
`default_nettype wire

// ---- inc/lmpu_pkg.sv ----
package lmpu_pkg;

  // Register word offsets (byte addresses)
  localparam logic [7:0] OFF_MODE    = 8'h00;
  localparam logic [7:0] OFF_BANK    = 8'h04;
  localparam logic [7:0] OFF_CFG     = 8'h08;
  localparam logic [7:0] OFF_INDEX   = 8'h0c;
  localparam logic [7:0] OFF_ATTR    = 8'h10;
  localparam logic [7:0] OFF_UPPER   = 8'h14;
  localparam logic [7:0] OFF_LOWER   = 8'h18;
  localparam logic [7:0] OFF_IDENT   = 8'h1c;
  localparam logic [7:0] OFF_STATUS  = 8'h20;

  // prot_mode_reg fields
  localparam int MODE_PE_BIT  = 0;
  localparam int MODE_SVP_BIT = 1;
  localparam int MODE_GPE_BIT = 2;

  // entry_attribute_reg fields
  localparam int ATTR_UR_BIT    = 0;
  localparam int ATTR_UW_BIT    = 1;
  localparam int ATTR_UX_BIT    = 2;
  localparam int ATTR_SR_BIT    = 3;
  localparam int ATTR_SW_BIT    = 4;
  localparam int ATTR_SX_BIT    = 5;
  localparam int ATTR_EN_BIT    = 7;
  localparam int ATTR_GUEST_BIT = 8;
  localparam int ATTR_ID_LSB    = 16;

  localparam logic [31:0] MODE_RESET  = 32'h0000_0000;
  localparam logic [31:0] BANK_RESET  = 32'h0000_0000;
  localparam logic [31:0] ENTRY_RESET = 32'h0000_0000;
  localparam logic [31:0] IDENT_RESET = 32'h0000_0000;

  // Bulk transfer words per entry: attribute, upper, lower
  localparam int WORDS_PER_ENTRY = 3;

  typedef struct packed {
    logic [31:0] attr;
    logic [31:0] upper;
    logic [31:0] lower;
  } lmpu_entry_t;

  typedef struct packed {
    logic        valid;
    logic [31:0] addr;
    logic        rd;
    logic        wr;
    logic        ex;
    logic        sv;
    logic        guest;
  } lmpu_acc_t;

  typedef struct packed {
    logic       violation;
    logic [2:0] xwr;
  } lmpu_res_t;

endpackage : lmpu_pkg

// ---- verification/lmpu_mem_model.sv ----
`timescale 1ns/1ps
`default_nettype none

// Memory seen by the bulk port; delay slows answers, err_word faults one word
module lmpu_mem_model (
  // Clock and reset
  input  wire logic        ref_clk,
  input  wire logic        rst_n,
  // Bulk request side
  input  wire logic        bulk_req,
  input  wire logic        bulk_we,
  input  wire logic [31:0] bulk_addr,
  input  wire logic [31:0] bulk_wdata,
  // Behaviour knobs
  input  wire logic [3:0]  delay,
  input  wire logic [7:0]  err_word,
  // Answers
  output logic             bulk_ack,
  output logic             bulk_err,
  output logic [31:0]      bulk_rdata
);
  logic [31:0] mem [0:31];
  logic [3:0]  cnt;
  wire  [4:0]  w   = bulk_addr[6:2];
  wire         bad = ({3'h0, w} == err_word);

  // Plain always so the bench may preload memory words directly
  always @(posedge ref_clk) begin
    if (!rst_n) begin
      bulk_ack <= 1'b0;
      bulk_err <= 1'b0;
      cnt      <= 4'h0;
    end else if (bulk_ack || bulk_err) begin
      bulk_ack <= 1'b0;
      bulk_err <= 1'b0;
      cnt      <= 4'h0;
    end else if (bulk_req && cnt == delay) begin
      bulk_ack <= !bad;
      bulk_err <= bad;
      if (bulk_we && !bad)
        mem[w] <= bulk_wdata;
    end else begin
      cnt <= bulk_req ? cnt + 4'h1 : 4'h0;
    end
  end

  // Read data only holds with ack; otherwise it toggles so stale use shows
  always_ff @(posedge ref_clk) begin
    if (bulk_req && !bulk_ack && !bulk_err && cnt == delay)
      bulk_rdata <= mem[w];
    else
      bulk_rdata <= ~bulk_rdata;
  end
endmodule : lmpu_mem_model

`default_nettype wire

// ---- verification/tb_top.sv ----
`timescale 1ns/1ps
`default_nettype none

module tb_top;
  import lmpu_pkg::*;
  logic        ref_clk = 0, rst_n = 0, virt_mode = 1, core_guest = 0;
  logic        bss = 0, bls = 0, cyc = 0, stb = 0, we = 0;
  logic [7:0]  adr = 8'h00, merr = 8'hff;
  logic [31:0] dat = 32'h0, base = 32'h0, q;
  logic [3:0]  mdly = 4'h0;
  lmpu_acc_t   acc = '0;
  logic        acc_valid, breq, bwe, back, berr, busy, fault, e;
  lmpu_res_t   acc_res;
  logic [31:0] baddr, bwd, brd, wb_dat_o;
  logic        wb_ack_o, wb_err_o;
  int          fail_count = 0, num_checks = 0;

  always #12.5 ref_clk = ~ref_clk;

  lmpu_check i_lmpu_check (.ref_clk(ref_clk), .rst_n(rst_n), .virt_mode(virt_mode),
    .core_guest(core_guest), .acc(acc), .acc_valid(acc_valid), .acc_res(acc_res),
    .bulk_store_start(bss), .bulk_load_start(bls), .bulk_req(breq), .bulk_we(bwe),
    .bulk_addr(baddr), .bulk_wdata(bwd), .bulk_ack(back), .bulk_err(berr),
    .bulk_rdata(brd), .bulk_base(base), .bulk_busy(busy), .bulk_fault(fault),
    .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hf),
    .wb_dat_i(dat), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .wb_err_o(wb_err_o));

  lmpu_mem_model i_lmpu_mem_model (.ref_clk(ref_clk), .rst_n(rst_n), .bulk_req(breq),
    .bulk_we(bwe), .bulk_addr(baddr), .bulk_wdata(bwd), .delay(mdly), .err_word(merr),
    .bulk_ack(back), .bulk_err(berr), .bulk_rdata(brd));

  task automatic finish_test;
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : finish_test

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  // Classic cycle; entered right after a rising edge
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int i;
    cyc <= 1'b1;
    stb <= 1'b1;
    we  <= w;
    adr <= a;
    dat <= d;
    for (i = 0; i < 20; i++) begin
      @(posedge ref_clk);
      if (wb_ack_o === 1'b1 || wb_err_o === 1'b1) break;
    end
    if (i == 20) begin
      fail_count++;
      finish_test();
    end
    q = wb_dat_o;
    e = wb_err_o;
    cyc <= 1'b0;
    stb <= 1'b0;
    we  <= 1'b0;
    @(posedge ref_clk);
  endtask : wb

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    wb(1'b1, a, d);
  endtask : wr

  task automatic rdchk(input logic [7:0] a, input logic [31:0] x);
    wb(1'b0, a, 32'h0);
    check(q, x);
  endtask : rdchk

  task automatic ent(input logic [31:0] i, at, up, lo);
    wr(OFF_INDEX, i);
    wr(OFF_ATTR, at);
    wr(OFF_UPPER, up);
    wr(OFF_LOWER, lo);
  endtask : ent

  // Mode is always written from host side, then guest state set to g
  task automatic md(input logic g, pe, svp, gpe);
    core_guest <= 1'b0;
    wr(OFF_MODE, {29'h0, gpe, svp, pe});
    core_guest <= g;
  endtask : md

  // k = {ex,wr,rd}; x = {violation,X,W,R}; result lands one cycle later
  task automatic chk(input logic [31:0] a, input logic [2:0] k, input logic s,
                     input logic [3:0] x);
    acc <= {1'b1, a, k[0], k[1], k[2], s, core_guest};
    @(posedge ref_clk);
    acc.valid <= 1'b0;
    @(posedge ref_clk);
    check({27'h0, acc_valid, acc_res}, {27'h0, 1'b1, x});
  endtask : chk

  task automatic bulk(input logic st);
    int i;
    if (st)
      bss <= 1'b1;
    else
      bls <= 1'b1;
    @(posedge ref_clk);
    bss <= 1'b0;
    bls <= 1'b0;
    for (i = 0; i < 2000; i++) begin
      @(posedge ref_clk);
      if (busy !== 1'b1) break;
    end
    if (i == 2000) begin
      fail_count++;
      finish_test();
    end
    @(posedge ref_clk);
  endtask : bulk

  initial begin
    repeat (20) @(posedge ref_clk);
    rst_n <= 1'b1;
    @(posedge ref_clk);
    rdchk(OFF_MODE, 32'h0);
    rdchk(OFF_BANK, 32'h0);
    wr(OFF_CFG, 32'hffff_ffff);
    rdchk(OFF_CFG, 32'h0000_0208);
    wb(1'b0, 8'hfc, 32'h0);
    check(e, 1'b1);
    ent(0, 32'h83, 32'h1fff, 32'h1000);
    ent(1, 32'h181, 32'h10ff, 32'h1000);
    ent(2, 32'h181, 32'h30ff, 32'h3000);
    wr(8'h38, 32'h5a);
    chk(32'h1100, 3'b001, 0, 4'b0111);
    md(0, 1, 0, 0);
    chk(32'h1100, 3'b010, 0, 4'b0011);
    chk(32'h3000, 3'b001, 0, 4'b1000);
    chk(32'h3000, 3'b001, 1, 4'b0111);
    md(0, 1, 1, 0);
    chk(32'h3000, 3'b001, 1, 4'b1000);
    md(1, 0, 0, 1);
    chk(32'h1010, 3'b001, 0, 4'b0011);
    md(1, 1, 0, 1);
    chk(32'h1010, 3'b001, 0, 4'b0001);
    chk(32'h1010, 3'b010, 0, 4'b1001);
    chk(32'h1200, 3'b001, 0, 4'b1000);
    chk(32'h3010, 3'b001, 0, 4'b1000);
    chk(32'h1010, 3'b001, 1, 4'b1000);
    md(1, 1, 0, 0);
    chk(32'h1010, 3'b001, 0, 4'b0001);
    wr(OFF_INDEX, 32'h0);
    wr(OFF_ATTR, 32'h0);
    rdchk(OFF_ATTR, 32'h83);
    wr(OFF_INDEX, 32'h1);
    wr(OFF_ATTR, 32'h189);
    rdchk(OFF_ATTR, 32'h189);
    wr(8'h38, 32'h0);
    rdchk(8'h38, 32'h5a);
    wr(OFF_BANK, 32'h1);
    rdchk(OFF_BANK, 32'h0);
    core_guest <= 1'b0;
    wr(OFF_BANK, 32'h1);
    chk(32'h1100, 3'b001, 0, 4'b1000);
    ent(0, 32'h87, 32'h1fff, 32'h1000);
    rdchk(OFF_ATTR, 32'h87);
    chk(32'h1100, 3'b100, 0, 4'b0111);
    wr(OFF_BANK, 32'h0);
    chk(32'h1100, 3'b001, 0, 4'b0011);
    rdchk(8'h38, 32'h5a);
    core_guest <= 1'b1;
    bulk(1'b1);
    check(i_lmpu_mem_model.mem[0], 32'h83);
    check(i_lmpu_mem_model.mem[1], 32'h1fff);
    check(i_lmpu_mem_model.mem[3], 32'h189);
    check(i_lmpu_mem_model.mem[7], 32'h30ff);
    // Restore runs as a guest load, so words of host slots are dropped
    i_lmpu_mem_model.mem[0] = 32'hdead;
    i_lmpu_mem_model.mem[3] = 32'h181;
    i_lmpu_mem_model.mem[4] = 32'h20ff;
    mdly <= 4'h3;
    bulk(1'b0);
    core_guest <= 1'b0;
    wr(OFF_INDEX, 32'h0);
    rdchk(OFF_ATTR, 32'h83);
    wr(OFF_INDEX, 32'h1);
    rdchk(OFF_ATTR, 32'h181);
    rdchk(OFF_UPPER, 32'h20ff);
    wr(OFF_BANK, 32'h1);
    wr(OFF_INDEX, 32'h0);
    rdchk(OFF_ATTR, 32'h87);
    wr(OFF_BANK, 32'h0);
    merr <= 8'h05;
    bulk(1'b1);
    check(fault, 1'b1);
    finish_test();
  end
endmodule : tb_top

`default_nettype wire
